/* core/ddr_wr_ctrl.sv */
// controller end: wishbone registers, beat fifo, command and burst driver
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`default_nettype none
module ddr_wr_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset, high
  input wire logic in_valid_i, // push request
  output logic in_ready_o, // room available
  input wire logic [W-1:0] in_data_i, // push data
  output logic out_valid_o, // data available
  input wire logic out_ready_i, // pop request
  output logic [W-1:0] out_data_o, // head data
  output logic [$clog2(DEPTH):0] count_o // words held
);
  localparam int AW = $clog2(DEPTH);
  initial if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("depth must be power of two");
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic push;
  logic pop;
  assign in_ready_o = count_o != (AW+1)'(DEPTH);
  assign out_valid_o = count_o != '0;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_ready_i & out_valid_o;
  assign out_data_o = mem_q[rp_q];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
      count_o <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      count_o <= count_o + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge clk_i) begin
    if (push) mem_q[wp_q] <= in_data_i;
  end
endmodule

module ddr_wr_ctrl
  import ddr_wr_pkg::*;
#(
  parameter int DQ_W = ddr_wr_pkg::DQ_W,
  parameter int AL = AL_CK,
  parameter int WRITE_COLUMN_LATENCY = CWL_CK,
  parameter int WR = WR_CK,
  parameter int WTR = WTR_CK,
  parameter int WR_DBI = WR_DBI_CK,
  parameter int WTR_DBI = WTR_DBI_CK
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset, high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // write enable
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte selects
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  ddr_wr_if.ctrl link // link to dram
);
  localparam int NB = DQ_W / 8;
  localparam int FW = DQ_W + NB;
  localparam int WL = AL + WRITE_COLUMN_LATENCY;
  localparam int LAST = 2 * CK_HALF - 1;
  initial begin
    if (FW > 32 || DQ_W % 8 != 0) $error("beat does not fit a word");
    if (WL < 1 || WL > 255 || CK_HALF < 2) $error("latency or divider out of range");
  end

  typedef enum logic [1:0] {C_IDLE, C_CMD, C_LAT, C_BURST} cstate_t;

  // link clock divider; ck high for div 0..CK_HALF-1
  logic [7:0] div_q;
  logic ck_q;
  logic rise;
  logic fall;
  logic half;
  logic mid;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= 8'h00;
      ck_q <= 1'b1;
    end else begin
      div_q <= (div_q == 8'(LAST)) ? 8'h00 : div_q + 8'h01;
      ck_q <= (div_q == 8'(LAST)) || (div_q < 8'(CK_HALF - 1));
    end
  end
  assign rise = div_q == 8'h00;
  assign fall = div_q == 8'(CK_HALF);
  assign half = rise | fall;
  assign mid = (div_q == 8'(CK_HALF / 2)) || (div_q == 8'(CK_HALF + CK_HALF / 2));

  cstate_t st_q;
  logic pend_q;
  logic [2:0] op_q;
  logic [2:0] ba_q;
  logic [13:0] addr_q;
  logic [1:0] mr0_q;
  logic dbi_q;
  logic [3:0] len_q;
  logic [2:0] beat_q;
  logic [7:0] lat_q;
  logic [7:0] wr_cnt_q;
  logic [7:0] wtr_cnt_q;

  // wishbone slave; ack withheld while the target cannot take it
  logic req;
  logic hit_ctrl;
  logic hit_wdata;
  logic ok;
  logic f_in_ready;
  logic f_out_valid;
  logic f_pop;
  logic [FW-1:0] f_data;
  logic [$clog2(FIFO_DEPTH):0] f_count;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign hit_ctrl = wb_adr_i == REG_CTRL;
  assign hit_wdata = wb_adr_i == REG_WDATA;
  assign ok = !wb_we_i || (hit_ctrl ? (!pend_q && st_q == C_IDLE)
                                    : (!hit_wdata || f_in_ready));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & ok;
      wb_dat_o <= 32'h0000_0000;
      if (req && !wb_we_i && wb_adr_i == REG_STATUS) begin
        wb_dat_o[ST_BUSY] <= pend_q | (st_q != C_IDLE);
        wb_dat_o[ST_EMPTY] <= ~f_out_valid;
        wb_dat_o[ST_FULL] <= ~f_in_ready;
        wb_dat_o[ST_DBI] <= dbi_q;
      end
    end
  end

  ddr_wr_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(req & wb_we_i & hit_wdata & (&wb_sel_i)),
    .in_ready_o(f_in_ready),
    .in_data_i(wb_dat_i[FW-1:0]),
    .out_valid_o(f_out_valid),
    .out_ready_i(f_pop),
    .out_data_o(f_data),
    .count_o(f_count)
  );

  // issue gate: writes wait for a full burst of beats, reads and precharges for recovery
  logic go;
  logic [3:0] need;
  assign need = burst_beats(mr0_q, addr_q[BIT_A12]);
  always_comb begin
    case (op_q)
      OP_WR: go = f_count >= need;
      OP_RD: go = wtr_cnt_q == 8'h00;
      OP_PRE: go = wr_cnt_q == 8'h00;
      default: go = 1'b1;
    endcase
  end
  // beats are even, so the last one always ends on a rising edge
  assign f_pop = (st_q == C_LAT && rise && lat_q + 8'h01 == 8'(WL))
               || (st_q == C_BURST && half && {1'b0, beat_q} != len_q - 4'h1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= C_IDLE;
      pend_q <= 1'b0;
      op_q <= OP_NOP;
      ba_q <= 3'h0;
      addr_q <= 14'h0000;
      len_q <= BEATS8;
      beat_q <= 3'h0;
      lat_q <= 8'h00;
      link.cmd <= OP_NOP;
      link.ba <= 3'h0;
      link.addr <= 14'h0000;
      link.dq <= '0;
      link.write_mask_pin <= '1;
      link.dqs <= 1'b0;
    end else begin
      if (req && ok && wb_we_i && hit_ctrl) begin
        pend_q <= 1'b1;
        op_q <= wb_dat_i[CTRL_OP_LSB +: 3];
        ba_q <= wb_dat_i[CTRL_BA_LSB +: 3];
        addr_q <= wb_dat_i[CTRL_ADDR_LSB +: 14];
      end
      case (st_q)
        C_IDLE: begin
          // command placed at a fall so the dram sees it settled at the rise
          if (pend_q && fall && go) begin
            pend_q <= 1'b0;
            link.cmd <= op_q;
            link.ba <= ba_q;
            link.addr <= addr_q;
            len_q <= need;
            st_q <= C_CMD;
          end
        end
        C_CMD: begin
          if (fall) begin
            link.cmd <= OP_NOP;
            lat_q <= 8'h00;
            st_q <= (op_q == OP_WR) ? C_LAT : C_IDLE;
          end
        end
        C_LAT: begin
          if (rise) begin
            lat_q <= lat_q + 8'h01;
            if (lat_q + 8'h01 == 8'(WL)) begin
              link.dq <= f_data[DQ_W-1:0];
              link.write_mask_pin <= f_data[FW-1:DQ_W];
              beat_q <= 3'h0;
              st_q <= C_BURST;
            end
          end
        end
        C_BURST: begin
          // strobe toggles mid-beat, evenly, for every beat
          if (mid) link.dqs <= ~link.dqs;
          if (half) begin
            if ({1'b0, beat_q} == len_q - 4'h1) begin
              link.write_mask_pin <= '1;
              st_q <= C_IDLE;
            end else begin
              link.dq <= f_data[DQ_W-1:0];
              link.write_mask_pin <= f_data[FW-1:DQ_W];
              beat_q <= beat_q + 3'h1;
            end
          end
        end
        default: st_q <= C_IDLE;
      endcase
    end
  end

  // shadow of mode fields the controller must obey
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mr0_q <= BURST_FIXED8;
      dbi_q <= 1'b0;
    end else if (st_q == C_IDLE && pend_q && fall && go && op_q == OP_MRS) begin
      if (ba_q == MR_SEL_ZERO) mr0_q <= addr_q[1:0];
      if (ba_q == MR_SEL_FIVE) dbi_q <= addr_q[BIT_A11];
    end
  end

  // recovery counters start at the rise after the last beat
  logic burst_end;
  assign burst_end = st_q == C_BURST && rise && {1'b0, beat_q} == len_q - 4'h1;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_cnt_q <= 8'h00;
      wtr_cnt_q <= 8'h00;
    end else if (burst_end) begin
      wr_cnt_q <= dbi_q ? 8'(WR_DBI) : 8'(WR);
      wtr_cnt_q <= dbi_q ? 8'(WTR_DBI) : 8'(WTR);
    end else if (rise) begin
      if (wr_cnt_q != 8'h00) wr_cnt_q <= wr_cnt_q - 8'h01;
      if (wtr_cnt_q != 8'h00) wtr_cnt_q <= wtr_cnt_q - 8'h01;
    end
  end

  assign link.ck = ck_q;
endmodule
`default_nettype wire

/* core/ddr_wr_pkg.sv */
// shared constants for the write-burst link between controller and dram
`default_nettype none
package ddr_wr_pkg;
  // link timing, in system clocks per half link-clock period, and link data width in bits
  localparam int CK_HALF = 8;
  localparam int DQ_W = 8;
  // latencies and recovery intervals, in link clock cycles
  localparam int AL_CK = 0;
  localparam int CWL_CK = 9;
  localparam int WR_CK = 16;
  localparam int WTR_CK = 8;
  localparam int WR_DBI_CK = 17;
  localparam int WTR_DBI_CK = 9;
  // link command codes
  localparam logic [2:0] OP_NOP = 3'h0;
  localparam logic [2:0] OP_WR = 3'h1;
  localparam logic [2:0] OP_RD = 3'h2;
  localparam logic [2:0] OP_MRS = 3'h3;
  localparam logic [2:0] OP_PRE = 3'h4;
  // mode register selects and fields
  localparam logic [2:0] MR_SEL_ZERO = 3'h0;
  localparam logic [2:0] MR_SEL_ONE = 3'h1;
  localparam logic [2:0] MR_SEL_FIVE = 3'h5;
  localparam logic [13:0] MR_RESET = 14'h0000;
  localparam int BIT_A11 = 11;
  localparam int BIT_A12 = 12;
  localparam logic [1:0] BURST_FIXED8 = 2'h0;
  localparam logic [1:0] BURST_OTF = 2'h1;
  localparam logic [1:0] BURST_CHOP4 = 2'h2;
  localparam logic [3:0] BEATS8 = 4'h8;
  localparam logic [3:0] BEATS4 = 4'h4;
  // controller register map (byte offsets)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_BA_LSB = 4;
  localparam int CTRL_ADDR_LSB = 16;
  localparam int ST_BUSY = 0;
  localparam int ST_EMPTY = 1;
  localparam int ST_FULL = 2;
  localparam int ST_DBI = 3;
  localparam int FIFO_DEPTH = 8;

  function automatic logic [3:0] burst_beats(input logic [1:0] fld, input logic a12);
    case (fld)
      BURST_FIXED8: burst_beats = BEATS8;
      BURST_OTF: burst_beats = a12 ? BEATS8 : BEATS4;
      default: burst_beats = BEATS4;
    endcase
  endfunction
endpackage
`default_nettype wire

/* core/ddr_wr_if.sv */
// link wires between the memory controller and the dram
`default_nettype none
interface ddr_wr_if #(parameter int DQ_W = 8);
  localparam int NB = DQ_W / 8;
  logic ck;
  logic [2:0] cmd;
  logic [2:0] ba;
  logic [13:0] addr;
  logic [DQ_W-1:0] dq;
  logic [NB-1:0] write_mask_pin;
  logic dqs;
  modport ctrl (output ck, cmd, ba, addr, dq, write_mask_pin, dqs);
  modport dram (input ck, cmd, ba, addr, dq, write_mask_pin, dqs);
endinterface
`default_nettype wire

/* core/ddr_wr_dram.sv */
// dram end: mode registers, write latency, burst capture, mask handling
`default_nettype none
module ddr_wr_dram
  import ddr_wr_pkg::*;
#(
  parameter int DQ_W = ddr_wr_pkg::DQ_W,
  parameter int GROUPS = 4,
  parameter int AL = AL_CK,
  parameter int WRITE_COLUMN_LATENCY = CWL_CK
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset, high
  ddr_wr_if.dram link, // link from controller
  input wire logic [$clog2(GROUPS*8)-1:0] rd_addr_i, // array peek address
  output logic [DQ_W-1:0] rd_data_o, // array peek data
  output logic [1:0] burst_field_o, // mode zero burst field
  output logic termination_data_strobe_en_o, // termination strobe mode
  output logic dbi_en_o, // write inversion mode
  output logic term_strobe_o, // termination strobe level
  output logic burst_end_o, // pulse: recovery start
  output logic burst_end_dbi_o, // burst used inversion
  output logic read_seen_o // pulse: read command seen
);
  localparam int NB = DQ_W / 8;
  localparam int AW = $clog2(GROUPS * 8);
  localparam int GW = AW - 3;
  localparam int WL = AL + WRITE_COLUMN_LATENCY;
  localparam int SW = 1 + 3 + 3 + 14 + DQ_W + NB + 1;

  initial begin
    if (DQ_W % 8 != 0 || DQ_W < 8) $error("data width must be whole bytes");
    if (GROUPS < 2 || (GROUPS & (GROUPS - 1)) != 0) $error("groups must be power of two");
    if (WL < 1 || WL > 255) $error("write latency out of range");
  end

  typedef enum logic [1:0] {S_IDLE, S_LAT, S_BURST, S_END} wstate_t;

  // every link pin passes two flops; the first is read by nothing else
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic ck_prev_q;
  logic dqs_prev_q;
  logic ck_s;
  logic [2:0] cmd_s;
  logic [2:0] ba_s;
  logic [13:0] addr_s;
  logic [DQ_W-1:0] dq_s;
  logic [NB-1:0] mask_s;
  logic dqs_s;
  logic rise;
  logic dqs_edge;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {link.ck, link.cmd, link.ba, link.addr, link.dq,
                  link.write_mask_pin, link.dqs};
      sync2_q <= sync1_q;
    end
  end

  assign {ck_s, cmd_s, ba_s, addr_s, dq_s, mask_s, dqs_s} = sync2_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ck_prev_q <= 1'b0;
      dqs_prev_q <= 1'b0;
    end else begin
      ck_prev_q <= ck_s;
      dqs_prev_q <= dqs_s;
    end
  end

  assign rise = ck_s & ~ck_prev_q;
  // strobe is double rate: both edges carry a beat
  assign dqs_edge = dqs_s ^ dqs_prev_q;

  // mode registers, loaded by a mode-set command at a rising link edge
  logic [13:0] mr0_q;
  logic [13:0] mr1_q;
  logic [13:0] mr5_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mr0_q <= MR_RESET;
      mr1_q <= MR_RESET;
      mr5_q <= MR_RESET;
    end else if (rise && cmd_s == OP_MRS) begin
      case (ba_s)
        MR_SEL_ZERO: mr0_q <= addr_s;
        MR_SEL_ONE: mr1_q <= addr_s;
        MR_SEL_FIVE: mr5_q <= addr_s;
        default: ;
      endcase
    end
  end

  assign burst_field_o = mr0_q[1:0];
  assign termination_data_strobe_en_o = mr1_q[BIT_A11];
  assign dbi_en_o = mr5_q[BIT_A11];

  // write sequencer
  wstate_t st_q;
  logic [7:0] lat_q;
  logic [3:0] len_q;
  logic [2:0] beat_q;
  logic [GW-1:0] grp_q;
  logic termination_data_strobe_q;
  logic dbi_q;

  // a second write while one is in flight is dropped: no pipelining
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= S_IDLE;
      lat_q <= 8'h00;
      len_q <= BEATS8;
      beat_q <= 3'h0;
      grp_q <= '0;
      termination_data_strobe_q <= 1'b0;
      dbi_q <= 1'b0;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (rise && cmd_s == OP_WR) begin
            len_q <= burst_beats(mr0_q[1:0], addr_s[BIT_A12]);
            grp_q <= addr_s[AW-1:3];
            termination_data_strobe_q <= mr1_q[BIT_A11];
            dbi_q <= mr5_q[BIT_A11];
            lat_q <= 8'h00;
            st_q <= S_LAT;
          end
        end
        S_LAT: begin
          if (rise) begin
            lat_q <= lat_q + 8'h01;
            if (lat_q + 8'h01 == 8'(WL)) begin
              beat_q <= 3'h0;
              st_q <= S_BURST;
            end
          end
        end
        S_BURST: begin
          if (dqs_edge) begin
            beat_q <= beat_q + 3'h1;
            if ({1'b0, beat_q} == len_q - 4'h1) st_q <= S_END;
          end
        end
        S_END: begin
          if (rise) st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // recovery start marker, one pulse at the rise after the last beat
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      burst_end_o <= 1'b0;
      burst_end_dbi_o <= 1'b0;
    end else begin
      burst_end_o <= (st_q == S_END) && rise;
      if (st_q == S_END && rise) burst_end_dbi_o <= dbi_q;
    end
  end

  // reads return nothing on this path; the mask pin is not looked at
  always_ff @(posedge clk_i) begin
    if (rst_i) read_seen_o <= 1'b0;
    else read_seen_o <= rise && (cmd_s == OP_RD);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) term_strobe_o <= 1'b0;
    else term_strobe_o <= termination_data_strobe_q && (st_q == S_BURST) && mask_s[0];
  end

  // array of flops; one beat lands per strobe edge
  logic [DQ_W-1:0] mem_q [GROUPS*8];
  logic [AW-1:0] wr_idx;
  logic [DQ_W-1:0] wr_val;
  logic [NB-1:0] wr_lane;

  assign wr_idx = {grp_q, beat_q};

  always_comb begin
    wr_val = dq_s;
    wr_lane = '0;
    for (int i = 0; i < NB; i++) begin
      if (termination_data_strobe_q) begin
        wr_lane[i] = 1'b1;
      end else if (dbi_q) begin
        wr_lane[i] = 1'b1;
        // low flag means the lane was sent inverted
        if (!mask_s[i]) wr_val[i*8 +: 8] = ~dq_s[i*8 +: 8];
      end else begin
        wr_lane[i] = mask_s[i];
      end
    end
  end

  // chopped bursts stop after four edges, so beats 4..7 stay as they were
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int j = 0; j < GROUPS * 8; j++) mem_q[j] <= '0;
    end else if (st_q == S_BURST && dqs_edge) begin
      for (int i = 0; i < NB; i++) begin
        if (wr_lane[i]) mem_q[wr_idx][i*8 +: 8] <= wr_val[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) rd_data_o <= '0;
    else rd_data_o <= mem_q[rd_addr_i];
  end
endmodule
`default_nettype wire

/* sim/ddr_wr_props.sv */
// link-side assertions between the controller end and the dram end
`default_nettype none
module ddr_wr_props
  import ddr_wr_pkg::*;
#(
  parameter int DQ_W = 8
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset, high
  input wire logic ck, // link clock
  input wire logic [2:0] cmd, // link command
  input wire logic [2:0] ba, // mode select
  input wire logic [13:0] addr, // column or mode value
  input wire logic [DQ_W-1:0] dq, // write data
  input wire logic [DQ_W/8-1:0] write_mask_pin, // mask lanes
  input wire logic dqs // data strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ck_q, dqs_q, seen_q, inv_q, invw_q, rise, done;
  logic [1:0] fld_q;
  logic [3:0] beats_q, exp_q;
  logic [7:0] rises_q, since_q;
  assign rise = ck & ~ck_q;
  assign done = seen_q && beats_q == exp_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i) begin
    ck_q <= ck;
    dqs_q <= dqs;
  end
  // mode shadow taken straight off the wire, independent of the dram's copy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fld_q <= 2'h0;
      inv_q <= 1'b0;
    end else if (rise && cmd == OP_MRS) begin
      if (ba == MR_SEL_ZERO) fld_q <= addr[1:0];
      if (ba == MR_SEL_FIVE) inv_q <= addr[BIT_A11];
    end
  end
  // since_q holds k-1 when sampled at the k-th rise after the last beat
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seen_q <= 1'b0;
      invw_q <= 1'b0;
      beats_q <= 4'h0;
      exp_q <= 4'h0;
      rises_q <= 8'h00;
      since_q <= 8'h00;
    end else if (rise && cmd == OP_WR) begin
      seen_q <= 1'b1;
      invw_q <= inv_q;
      beats_q <= 4'h0;
      rises_q <= 8'h00;
      since_q <= 8'h00;
      exp_q <= (fld_q == BURST_FIXED8 || (fld_q == BURST_OTF && addr[BIT_A12])) ? 4'h8 : 4'h4;
    end else begin
      if (dqs != dqs_q) beats_q <= beats_q + 4'h1;
      if (rise && rises_q != 8'hff) rises_q <= rises_q + 8'h01;
      if (rise && done && since_q != 8'hff) since_q <= since_q + 8'h01;
    end
  end
  AST_CK_HALF: assert property ($changed(ck) |=> $stable(ck) [*7])
    else $error("link clock half period too short");
  // link pins are registered, so they move one system clock after the ck edge
  AST_CMD_AT_FALL: assert property ($changed(cmd) |-> !$past(ck) && $past(ck, 2))
    else $error("command changed away from a falling link clock");
  AST_DATA_AT_EDGE: assert property ($changed({dq, write_mask_pin}) |->
    $past(ck) != $past(ck, 2))
    else $error("data or mask moved away from a link clock edge");
  AST_DQS_CENTRED: assert property ($changed(dqs) |-> $stable({dq, write_mask_pin})
    ##1 $stable({dq, write_mask_pin}) [*3])
    else $error("strobe edge not centred in data");
  AST_FIRST_BEAT: assert property ($changed(dqs) && seen_q && beats_q == 4'h0 |->
    rises_q == AL_CK + CWL_CK)
    else $error("first strobe edge at wrong latency");
  AST_NO_LATE_BEAT: assert property (seen_q && beats_q == 4'h0 |->
    rises_q <= AL_CK + CWL_CK)
    else $error("first beat missing after latency");
  AST_BEAT_COUNT: assert property (rise && cmd != OP_NOP && seen_q |-> beats_q == exp_q)
    else $error("burst beat count wrong");
  AST_PRE_RECOVERY: assert property (rise && cmd == OP_PRE && seen_q |->
    since_q >= (invw_q ? WR_DBI_CK : WR_CK))
    else $error("precharge before write recovery");
  AST_RD_AFTER_WR: assert property (rise && cmd == OP_RD && seen_q |->
    since_q >= (invw_q ? WTR_DBI_CK : WTR_CK))
    else $error("read too soon after write");
  cover property (rise && cmd == OP_WR && fld_q == BURST_OTF && !addr[BIT_A12]);
  cover property (rise && cmd == OP_PRE && invw_q);
  cover property (rise && cmd == OP_RD && seen_q);
endmodule
`default_nettype wire

/* sim/tb_sdram_write_burst_mask_path.sv */
// bench: wishbone-driven controller writing bursts into the dram end
`default_nettype none
module tb_sdram_write_burst_mask_path import ddr_wr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, rst_i, cyc, stb, we, ack, term_en, inv_en, term_lvl, end_p, inv_end, rd_p;
  logic [7:0] adr, rd_data;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [4:0] rd_addr;
  logic [1:0] burst_fld;
  logic [7:0] mdl [32];
  int n_fail, tests_run, n_end, n_rd, n_term;
  ddr_wr_if #(.DQ_W(DQ_W)) lnk();
  ddr_wr_ctrl i_ddr_wr_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .link(lnk.ctrl));
  ddr_wr_dram i_ddr_wr_dram (.clk_i(clk_i), .rst_i(rst_i), .link(lnk.dram),
    .rd_addr_i(rd_addr), .rd_data_o(rd_data), .burst_field_o(burst_fld), .termination_data_strobe_en_o(term_en),
    .dbi_en_o(inv_en), .term_strobe_o(term_lvl), .burst_end_o(end_p),
    .burst_end_dbi_o(inv_end), .read_seen_o(rd_p));
  ddr_wr_props i_ddr_wr_props (.clk_i(clk_i), .rst_i(rst_i), .ck(lnk.ck), .cmd(lnk.cmd),
    .ba(lnk.ba), .addr(lnk.addr), .dq(lnk.dq), .write_mask_pin(lnk.write_mask_pin),
    .dqs(lnk.dqs));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (end_p === 1'b1) n_end++;
    if (rd_p === 1'b1) n_rd++;
    if (term_lvl === 1'b1) n_term++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic hang();
    n_fail++;
    test_done();
  endtask
  // ack is read before this edge's updates land, i.e. as sampled at the edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 200);
    if (n >= 200) hang();
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic ctrl(input logic [2:0] op, input logic [2:0] b, input logic [13:0] a);
    logic [31:0] q;
    wb(1'b1, REG_CTRL, {2'h0, a, 9'h000, b, 1'h0, op}, 4'hf, q);
  endtask
  // the dram sees the link through synchronisers, so allow some slack at the end
  task automatic settle(input int ends);
    int n;
    logic [31:0] s;
    n = 0;
    do begin
      wb(1'b0, REG_STATUS, 32'h0, 4'hf, s);
      n++;
    end while ((s[ST_BUSY] !== 1'b0 || n_end != ends) && n < 600);
    if (n >= 600) hang();
    repeat (8) @(posedge clk_i);
  endtask
  task automatic peek(input logic [4:0] a);
    rd_addr <= a;
    repeat (2) @(posedge clk_i);
    chk(32'(rd_data), 32'(mdl[a]));
  endtask
  task automatic run_case(input logic [1:0] fld, input logic a12, input logic [1:0] g,
                          input logic t, input logic v);
    int len;
    int i;
    logic [8:0] bt;
    logic [31:0] s;
    logic [4:0] ad;
    int nt;
    logic anym;
    anym = 1'b0;
    ctrl(OP_MRS, MR_SEL_ZERO, {12'h000, fld});
    ctrl(OP_MRS, MR_SEL_ONE, 14'(t) << BIT_A11);
    ctrl(OP_MRS, MR_SEL_FIVE, 14'(v) << BIT_A11);
    settle(n_end);
    chk(32'({burst_fld, term_en, inv_en}), 32'({fld, t, v}));
    len = (fld == 2'h0 || (fld == 2'h1 && a12)) ? 8 : 4;
    for (i = 0; i < len; i++) begin
      bt = 9'($urandom);
      wb(1'b1, REG_WDATA, 32'(bt), 4'hf, s);
      ad = {g, 3'(i)};
      if (bt[8]) anym = 1'b1;
      if (v) mdl[ad] = bt[8] ? bt[7:0] : ~bt[7:0];
      else if (t || bt[8]) mdl[ad] = bt[7:0];
    end
    wb(1'b0, REG_STATUS, 32'h0, 4'hf, s);
    chk(s, (len == 8 ? 32'h4 : 32'h0) | 32'(v) << ST_DBI);
    nt = n_term;
    ctrl(OP_WR, 3'h0, 14'(a12) << BIT_A12 | 14'(g) << 3);
    settle(n_end + 1);
    chk(32'(n_term != nt), 32'(t && anym));
    chk(32'(inv_end), 32'(v));
    wb(1'b0, REG_STATUS, 32'h0, 4'hf, s);
    chk(s, 32'h2 | 32'(v) << ST_DBI);
    for (i = 0; i < 8; i++) peek({g, 3'(i)});
  endtask
  initial begin
    logic [31:0] s;
    int i;
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    rd_addr = 5'h00;
    for (i = 0; i < 32; i++) mdl[i] = 8'h00;
    void'($urandom(32'h639e));
    repeat (3) @(posedge clk_i);
    chk(32'({lnk.ck, lnk.cmd, lnk.write_mask_pin, lnk.dqs}), 32'h22);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, REG_STATUS, 32'h0, 4'hf, s);
    chk(s, 32'h2);
    wb(1'b1, 8'h0c, 32'hffff_ffff, 4'hf, s);
    wb(1'b0, 8'h0c, 32'h0, 4'hf, s);
    chk(s, 32'h0);
    // a partial-lane push must be dropped, or every later burst shifts by one beat
    wb(1'b1, REG_WDATA, 32'h1ff, 4'h3, s);
    wb(1'b0, REG_STATUS, 32'h0, 4'hf, s);
    chk(s, 32'h2);
    run_case(2'h0, 1'h0, 2'h0, 1'h0, 1'h0);
    run_case(2'h1, 1'h0, 2'h0, 1'h0, 1'h0);
    run_case(2'h1, 1'h1, 2'h1, 1'h0, 1'h0);
    run_case(2'h2, 1'h1, 2'h1, 1'h0, 1'h0);
    run_case(2'h3, 1'h0, 2'h2, 1'h0, 1'h0);
    run_case(2'h0, 1'h0, 2'h3, 1'h1, 1'h0);
    run_case(2'h1, 1'h1, 2'h2, 1'h0, 1'h1);
    run_case(2'h2, 1'h0, 2'h3, 1'h0, 1'h1);
    i = n_rd;
    ctrl(OP_RD, 3'h0, 14'h0018);
    settle(n_end);
    chk(32'(n_rd - i), 32'h1);
    ctrl(OP_PRE, 3'h0, 14'h0000);
    settle(n_end);
    for (i = 0; i < 32; i++) peek(5'(i));
    test_done();
  end
endmodule
`default_nettype wire
